// File: rtl/hirm_pkg.sv
/*
 * Shared constants and types for the host interrupt routing and mailbox block.
 * Assumes one system clock; the host bus and all event sources sit on that clock.
 */
package hirm_pkg;

    // -----------------------------------------------------------------
    // register word addresses
    // -----------------------------------------------------------------
    localparam logic [7:0] ADDR_MBOX_LO = 8'h20;
    localparam logic [7:0] ADDR_MBOX_HI = 8'h27;
    localparam logic [7:0] ADDR_WRITER = 8'h28;
    localparam logic [7:0] ADDR_MBOX_INDEX = 8'h29;
    localparam logic [7:0] ADDR_QUEUE_EN = 8'h30;
    localparam logic [7:0] ADDR_TIMER_RT = 8'h32;
    localparam logic [7:0] ADDR_TPROG_RT = 8'h33;
    localparam logic [7:0] ADDR_TIMER_EN = 8'h34;
    localparam logic [7:0] ADDR_LINK_RT = 8'h35;

    // -----------------------------------------------------------------
    // writable-bit masks and reset values
    // -----------------------------------------------------------------
    localparam logic [15:0] MASK_MBOX = 16'h00FF;
    localparam logic [15:0] MASK_INDEX = 16'h0007;
    localparam logic [15:0] MASK_QUEUE_EN = 16'h0F0F;
    localparam logic [15:0] MASK_TIMER_RT = 16'hFFFF;
    localparam logic [15:0] MASK_TPROG_RT = 16'h3FFF;
    localparam logic [15:0] MASK_TIMER_EN = 16'h7FFF;
    localparam logic [15:0] MASK_LINK_RT = 16'h00FF;
    localparam logic [15:0] RST_REG = 16'h0000;
    localparam logic [7:0] RST_BYTE = 8'h00;

    // field positions
    localparam int QEN_PKT_LSB = 0;
    localparam int QEN_RDY_LSB = 8;
    localparam int TEN_CAP_LSB = 0;
    localparam int TEN_CMP_LSB = 4;
    localparam int TEN_PROG_LSB = 8;
    localparam int TEN_TINT_LSB = 12;

    localparam int NUM_SLOTS = 8;
    localparam int NUM_IRQ = 3;
    localparam logic [1:0] ROUTE_RESERVED = 2'h3;

    // -----------------------------------------------------------------
    // carriers
    // -----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [31:0] wdata;
    } hirm_host_req_t;

    typedef struct packed {
        logic wr;
        logic [2:0] slot;
        logic [7:0] data;
    } hirm_pc_req_t;

    typedef struct packed {
        logic [3:0] queue_ready;
        logic [3:0] packet_ready;
        logic [3:0] capture;
        logic [3:0] compare;
        logic [3:0] timer_program;
        logic [2:0] timer_program_int;
        logic [1:0] periodic;
        logic [1:0] link_change;
    } hirm_events_t;

    // routing code to one-hot output vector; the reserved code hits nothing
    function automatic logic [2:0] route_hit(input logic [1:0] code);
        case (code)
            2'h0: route_hit = 3'h1;
            2'h1: route_hit = 3'h2;
            2'h2: route_hit = 3'h4;
            default: route_hit = 3'h0;
        endcase
    endfunction : route_hit

endpackage : hirm_pkg

// File: rtl/hirm_router.sv
/*
 * Routes N enabled event levels onto the three interrupt outputs by 2-bit codes.
 * Assumes events and enables are already combined by the caller; purely combinational.
 */
`timescale 1ns/1ps
`default_nettype none
module hirm_router #(
    parameter int N = 8
) (
    input wire logic [N-1:0] active,
    input wire logic [2*N-1:0] codes,
    output logic [2:0] hit
);
    import hirm_pkg::*;

    // -----------------------------------------------------------------
    // or-reduce per output
    // -----------------------------------------------------------------
    always_comb begin
        hit = 3'h0;
        for (int i = 0; i < N; i++) begin
            if (active[i]) begin
                hit = hit | route_hit(codes[2*i +: 2]);
            end
        end
    end
endmodule : hirm_router
`default_nettype wire

// File: rtl/hirm_top.sv
/*
 * Host interrupt routing and atomic mailbox: register file, eight-slot mailbox
 * shared with the protocol controller, and three routed interrupt outputs.
 * Assumes a synchronous host bus and event sources on mclk.
 */
`timescale 1ns/1ps
`default_nettype none
module hirm_top (
    input wire logic mclk,
    input wire logic reset,
    input wire logic ce,
    input wire hirm_pkg::hirm_host_req_t host_req,
    output logic [31:0] host_rdata,
    output logic host_rvalid,
    input wire hirm_pkg::hirm_pc_req_t pc_req,
    output logic [7:0] pc_rdata,
    input wire hirm_pkg::hirm_events_t events,
    output logic [2:0] irq
);
    import hirm_pkg::*;

    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    typedef struct packed {
        logic [NUM_SLOTS-1:0][7:0] mbox;
        logic [NUM_SLOTS-1:0] writer;
        logic [2:0] index;
        logic [15:0] queue_en;
        logic [15:0] timer_rt;
        logic [15:0] tprog_rt;
        logic [15:0] timer_en;
        logic [15:0] link_rt;
        logic [31:0] rdata;
        logic rvalid;
        logic [7:0] pc_rdata;
        logic [2:0] irq;
    } hirm_state_t;

    hirm_state_t state_ff;
    hirm_state_t nxt_state;

    // -----------------------------------------------------------------
    // event gating
    // -----------------------------------------------------------------
    logic [7:0] timer_active;
    logic [6:0] tprog_active;
    logic [3:0] link_active;
    logic [7:0] queue_active;
    logic [2:0] hit_timer;
    logic [2:0] hit_tprog;
    logic [2:0] hit_link;
    logic [2:0] hit_queue;

    assign timer_active = {events.compare & state_ff.timer_en[TEN_CMP_LSB +: 4],
                           events.capture & state_ff.timer_en[TEN_CAP_LSB +: 4]};
    assign tprog_active = {events.timer_program_int & state_ff.timer_en[TEN_TINT_LSB +: 3],
                           events.timer_program & state_ff.timer_en[TEN_PROG_LSB +: 4]};
    assign queue_active = {events.queue_ready & state_ff.queue_en[QEN_RDY_LSB +: 4],
                           events.packet_ready & state_ff.queue_en[QEN_PKT_LSB +: 4]};
    // periodic and link events carry no enable of their own here
    assign link_active = {events.periodic, events.link_change};

    // -----------------------------------------------------------------
    // routing
    // -----------------------------------------------------------------
    // compare and capture routing
    hirm_router #(.N(8)) u_route_timer (
        .active(timer_active),
        .codes(state_ff.timer_rt),
        .hit(hit_timer)
    );

    hirm_router #(.N(7)) u_route_tprog (
        .active(tprog_active),
        .codes(state_ff.tprog_rt[13:0]),
        .hit(hit_tprog)
    );

    hirm_router #(.N(4)) u_route_link (
        .active(link_active),
        .codes(state_ff.link_rt[7:0]),
        .hit(hit_link)
    );

    // queue events have no routing register in this block: fixed to output 0
    hirm_router #(.N(8)) u_route_queue (
        .active(queue_active),
        .codes(16'h0000),
        .hit(hit_queue)
    );

    // -----------------------------------------------------------------
    // host decode helpers
    // -----------------------------------------------------------------
    logic wr_mbox;
    logic rd_mbox;
    logic wr_index;
    logic wr_queue_en;
    logic wr_timer_rt;
    logic wr_tprog_rt;
    logic wr_timer_en;
    logic wr_link_rt;
    logic [15:0] wr16;

    // the eight slot addresses all land on the one indexed slot
    function automatic logic in_mbox_window(input logic [7:0] a);
        in_mbox_window = a >= ADDR_MBOX_LO && a <= ADDR_MBOX_HI;
    endfunction : in_mbox_window

    // full-word match keeps unmapped addresses from aliasing a register
    function automatic logic wr_hit(input hirm_host_req_t req, input logic [7:0] a);
        wr_hit = req.wr && req.addr == a;
    endfunction : wr_hit

    // any address in the slot window hits the indexed slot
    assign wr_mbox = host_req.wr && in_mbox_window(host_req.addr);
    assign rd_mbox = in_mbox_window(host_req.addr);
    assign wr_index = wr_hit(host_req, ADDR_MBOX_INDEX);
    assign wr_queue_en = wr_hit(host_req, ADDR_QUEUE_EN);
    assign wr_timer_rt = wr_hit(host_req, ADDR_TIMER_RT);
    assign wr_tprog_rt = wr_hit(host_req, ADDR_TPROG_RT);
    assign wr_timer_en = wr_hit(host_req, ADDR_TIMER_EN);
    assign wr_link_rt = wr_hit(host_req, ADDR_LINK_RT);
    assign wr16 = host_req.wdata[15:0];

    // -----------------------------------------------------------------
    // next state
    // -----------------------------------------------------------------
    always_comb begin
        logic [15:0] rd16;
        rd16 = 16'h0000;
        nxt_state = state_ff;

        // protocol controller writes first so a same-slot host write wins
        if (pc_req.wr) begin
            nxt_state.mbox[pc_req.slot] = pc_req.data;
            nxt_state.writer[pc_req.slot] = 1'b0;
        end
        nxt_state.pc_rdata = state_ff.mbox[pc_req.slot];

        if (wr_index) begin
            nxt_state.index = wr16[2:0] & MASK_INDEX[2:0];
        end
        if (wr_queue_en) begin
            nxt_state.queue_en = wr16 & MASK_QUEUE_EN;
        end
        if (wr_timer_rt) begin
            nxt_state.timer_rt = wr16 & MASK_TIMER_RT;
        end
        if (wr_tprog_rt) begin
            nxt_state.tprog_rt = wr16 & MASK_TPROG_RT;
        end
        if (wr_timer_en) begin
            nxt_state.timer_en = wr16 & MASK_TIMER_EN;
        end
        if (wr_link_rt) begin
            nxt_state.link_rt = wr16 & MASK_LINK_RT;
        end
        if (wr_mbox) begin
            nxt_state.mbox[state_ff.index] = wr16[7:0] & MASK_MBOX[7:0];
            nxt_state.writer[state_ff.index] = 1'b1;
        end

        // indexed read; other mapped addresses return register contents, unmapped addresses return zero
        if (rd_mbox) begin
            rd16 = {8'h00, state_ff.mbox[state_ff.index]};
        end else begin
            case (host_req.addr)
                ADDR_WRITER: rd16 = {8'h00, state_ff.writer};
                ADDR_MBOX_INDEX: rd16 = {13'h0, state_ff.index};
                ADDR_QUEUE_EN: rd16 = state_ff.queue_en;
                ADDR_TIMER_RT: rd16 = state_ff.timer_rt;
                ADDR_TPROG_RT: rd16 = state_ff.tprog_rt;
                ADDR_TIMER_EN: rd16 = state_ff.timer_en;
                ADDR_LINK_RT: rd16 = state_ff.link_rt;
                default: rd16 = 16'h0000;
            endcase
        end
        // value in low half, upper half zero
        nxt_state.rdata = host_req.rd ? {16'h0000, rd16} : 32'h0000_0000;
        nxt_state.rvalid = host_req.rd;

        nxt_state.irq = hit_timer | hit_tprog | hit_link | hit_queue;
    end

    // -----------------------------------------------------------------
    // registers
    // -----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (reset) begin
            state_ff <= '0;
        end else if (ce) begin
            state_ff <= nxt_state;
        end
    end

    assign host_rdata = state_ff.rdata;
    assign host_rvalid = state_ff.rvalid;
    assign pc_rdata = state_ff.pc_rdata;
    assign irq = state_ff.irq;

endmodule : hirm_top
`default_nettype wire

// File: testbench/hirm_chk.sv
/* checker for hirm_top: read answer timing, reserved bits, controller port, idle irq
   assumes ce held high and one clock, mclk */
`timescale 1ns/1ps
`default_nettype none
module hirm_chk (
    input wire logic mclk,
    input wire logic reset,
    input wire logic ce,
    input wire hirm_pkg::hirm_host_req_t host_req,
    input wire logic [31:0] host_rdata,
    input wire logic host_rvalid,
    input wire hirm_pkg::hirm_pc_req_t pc_req,
    input wire logic [7:0] pc_rdata,
    input wire hirm_pkg::hirm_events_t events,
    input wire logic [2:0] irq
);
    import hirm_pkg::*;
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    property p_rv; host_req.rd && ce |=> host_rvalid; endproperty
    a_rv: assert property (p_rv) else $error("read not answered");
    property p_idle; !host_req.rd |=> !host_rvalid && host_rdata == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("answer without read");
    property p_hi; host_rvalid |-> host_rdata[31:16] == 16'h0; endproperty
    a_hi: assert property (p_hi) else $error("upper half not zero");
    property p_wrs; host_req.rd && host_req.addr == ADDR_WRITER |=> host_rdata[15:8] == 8'h0;
    endproperty
    a_wrs: assert property (p_wrs) else $error("flags reserved bits");
    property p_qen; host_req.rd && host_req.addr == ADDR_QUEUE_EN
        |=> (host_rdata[15:0] & ~MASK_QUEUE_EN) == 16'h0; endproperty
    a_qen: assert property (p_qen) else $error("queue enable reserved bits");
    property p_tpr; host_req.rd && host_req.addr == ADDR_TPROG_RT |=> host_rdata[15:14] == 2'h0;
    endproperty
    a_tpr: assert property (p_tpr) else $error("program routing reserved bits");
    property p_ten; host_req.rd && host_req.addr == ADDR_TIMER_EN |=> !host_rdata[15];
    endproperty
    a_ten: assert property (p_ten) else $error("timer enable bit 15");
    property p_lnk; host_req.rd && host_req.addr == ADDR_LINK_RT |=> host_rdata[15:8] == 8'h0;
    endproperty
    a_lnk: assert property (p_lnk) else $error("link routing reserved bits");
    property p_pc; pc_req.wr && !host_req.wr ##1 $stable(pc_req.slot)
        |=> pc_rdata == $past(pc_req.data, 2); endproperty
    a_pc: assert property (p_pc) else $error("controller slot data");
    property p_quiet; events == '0 |=> irq == 3'h0; endproperty
    a_quiet: assert property (p_quiet) else $error("irq with no event");
    c_rd: cover property (host_rvalid && host_rdata[7:0] != 8'h0);
    c_irq2: cover property (irq[2]);
    c_pc: cover property (pc_req.wr);
endmodule : hirm_chk
bind hirm_top hirm_chk i_chk (.mclk(mclk), .reset(reset), .ce(ce), .host_req(host_req),
    .host_rdata(host_rdata), .host_rvalid(host_rvalid), .pc_req(pc_req),
    .pc_rdata(pc_rdata), .events(events), .irq(irq));
`default_nettype wire

// File: testbench/hirm_host_bfm.sv
/* host processor model: one-cycle read or write strobes on the register bus
   assumes the bus is synchronous to mclk with no wait states */
`timescale 1ns/1ps
`default_nettype none
module hirm_host_bfm (
    input wire logic mclk,
    output var hirm_pkg::hirm_host_req_t host_req
);
    import hirm_pkg::*;
    initial host_req = '0;
    task automatic access(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge mclk);
        #1;
        host_req = '{addr: a, wr: w, rd: !w, wdata: d};
        @(posedge mclk);
        #1;
        // released bus carries junk, never the last value
        host_req = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
    endtask : access
endmodule : hirm_host_bfm
`default_nettype wire

// File: testbench/testbench.sv
/* testbench for hirm_top: registers, mailbox, controller port, routed interrupts
   assumes package, design, checker and host model compiled first */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import hirm_pkg::*;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    hirm_host_req_t host_req;
    logic [31:0] host_rdata;
    logic host_rvalid;
    hirm_pc_req_t pc_req = '0;
    logic [7:0] pc_rdata;
    hirm_events_t events = '0;
    logic [2:0] irq;
    logic [31:0] q[$];
    int n_fail = 0;
    int total_checks = 0;
    integer seed = 32'h15d5;
    logic [7:0] radr [5] = '{ADDR_QUEUE_EN, ADDR_TIMER_RT, ADDR_TPROG_RT, ADDR_TIMER_EN,
        ADDR_LINK_RT};
    logic [15:0] rmsk [5] = '{MASK_QUEUE_EN, MASK_TIMER_RT, MASK_TPROG_RT, MASK_TIMER_EN,
        MASK_LINK_RT};
    logic [7:0] mb [8];
    logic [31:0] v;
    logic [31:0] ev;
    logic [15:0] trt, tpr, ten, qen, lrt;
    logic [2:0] exp_irq;
    always #2 mclk = ~mclk;
    hirm_host_bfm i_host (.mclk(mclk), .host_req(host_req));
    hirm_top i_dut (.mclk(mclk), .reset(reset), .ce(1'b1), .host_req(host_req),
        .host_rdata(host_rdata), .host_rvalid(host_rvalid), .pc_req(pc_req),
        .pc_rdata(pc_rdata), .events(events), .irq(irq));
    // ------------------------------------------------------------
    // compare and bus tasks
    // ------------------------------------------------------------
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : cmp
    task automatic chk_irq(input logic [2:0] e);
        repeat (3) @(posedge mclk);
        #1;
        cmp({29'h0, irq}, {29'h0, e}, "irq");
    endtask : chk_irq
    // reference routing: the reserved code reaches no output
    function automatic logic [2:0] ref_route(input logic [1:0] code);
        ref_route = code == 2'h3 ? 3'h0 : 3'(1 << code);
    endfunction : ref_route
    // software never writes the reserved code: a 11 pair becomes 01
    function automatic logic [15:0] no_rsv(input logic [15:0] r);
        no_rsv = r & ~((r & {r[14:0], 1'b0}) & 16'hAAAA);
    endfunction : no_rsv
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_host.access(a, 1'b1, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        q.push_back(e);
        i_host.access(a, 1'b0, 32'h0);
    endtask : rd
    task close_out;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : close_out
    // answers are matched in order against the noted expectations
    always @(posedge mclk) if (host_rvalid === 1'b1) begin
        if (q.size() == 0) begin
            n_fail++;
            $display("ERROR t=%0t answer without a pending read", $time);
        end else begin
            cmp(host_rdata, q.pop_front(), "read");
        end
    end
    initial begin
        repeat (6) @(posedge mclk);
        #1;
        reset = 1'b0;
        for (int i = 0; i < 5; i++) begin
            rd(radr[i], 32'h0);
            v = $random(seed);
            wr(radr[i], v);
            rd(radr[i], {16'h0, v[15:0] & rmsk[i]});
            wr(radr[i], 32'h0);
        end
        wr(8'h31, 32'hFFFFFFFF);
        rd(8'h31, 32'h0);
        $display("test registers done");
        for (int s = 0; s < 8; s++) begin
            mb[s] = 8'($random(seed));
            wr(ADDR_MBOX_INDEX, 32'(s));
            wr(8'(ADDR_MBOX_LO + 7 - s), {24'hFFFFFF, mb[s]});
        end
        rd(ADDR_WRITER, 32'hFF);
        for (int s = 0; s < 8; s++) begin
            wr(ADDR_MBOX_INDEX, 32'(s));
            rd(ADDR_MBOX_LO, {24'h0, mb[s]});
        end
        pc_req = '{wr: 1'b1, slot: 3'h5, data: 8'h3C};
        @(posedge mclk);
        #1;
        pc_req.wr = 1'b0;
        pc_req.data = 8'hC3;
        @(posedge mclk);
        #1;
        cmp({24'h0, pc_rdata}, 32'h3C, "controller read");
        rd(ADDR_WRITER, 32'hDF);
        wr(ADDR_MBOX_INDEX, 32'h5);
        rd(ADDR_MBOX_LO, 32'h3C);
        $display("test mailbox done");
        wr(ADDR_TIMER_EN, 32'h1);
        events.capture = 4'h1;
        for (int c = 3; c >= 0; c--) begin
            wr(ADDR_TIMER_RT, 32'(c));
            chk_irq(c < 3 ? 3'(1 << c) : 3'h0);
        end
        wr(ADDR_TIMER_EN, 32'h0);
        chk_irq(3'h0);
        events.capture = 4'h0;
        wr(ADDR_TPROG_RT, 32'h2000);
        wr(ADDR_TIMER_EN, 32'h4000);
        events.timer_program_int = 3'h4;
        chk_irq(3'h4);
        events.timer_program_int = 3'h0;
        wr(ADDR_LINK_RT, 32'h0084);
        events.link_change = 2'h2;
        chk_irq(3'h2);
        events.link_change = 2'h0;
        events.periodic = 2'h2;
        chk_irq(3'h4);
        events.periodic = 2'h0;
        wr(ADDR_QUEUE_EN, 32'h0200);
        events.queue_ready = 4'h2;
        chk_irq(3'h1);
        $display("test interrupts done");
        // random legal routing, enables and sparse events
        for (int k = 0; k < 8; k++) begin
            trt = no_rsv(16'($random(seed)));
            tpr = no_rsv(16'($random(seed))) & MASK_TPROG_RT;
            ten = 16'($random(seed)) & MASK_TIMER_EN;
            qen = 16'($random(seed)) & MASK_QUEUE_EN;
            lrt = no_rsv(16'($random(seed))) & MASK_LINK_RT;
            wr(ADDR_TIMER_RT, {16'h0, trt});
            wr(ADDR_TPROG_RT, {16'h0, tpr});
            wr(ADDR_TIMER_EN, {16'h0, ten});
            wr(ADDR_QUEUE_EN, {16'h0, qen});
            wr(ADDR_LINK_RT, {16'h0, lrt});
            ev = $random(seed) & $random(seed) & $random(seed);
            events = ev[26:0];
            exp_irq = 3'h0;
            for (int b = 0; b < 4; b++) begin
                if (events.capture[b] && ten[b]) exp_irq |= ref_route(trt[2*b +: 2]);
                if (events.compare[b] && ten[4+b]) exp_irq |= ref_route(trt[8+2*b +: 2]);
                if (events.timer_program[b] && ten[8+b]) exp_irq |= ref_route(tpr[2*b +: 2]);
                if (events.queue_ready[b] && qen[8+b]) exp_irq[0] = 1'b1;
                if (events.packet_ready[b] && qen[b]) exp_irq[0] = 1'b1;
            end
            for (int b = 0; b < 3; b++) begin
                if (events.timer_program_int[b] && ten[12+b]) begin
                    exp_irq |= ref_route(tpr[8+2*b +: 2]);
                end
            end
            for (int b = 0; b < 2; b++) begin
                if (events.link_change[b]) exp_irq |= ref_route(lrt[2*b +: 2]);
                if (events.periodic[b]) exp_irq |= ref_route(lrt[4+2*b +: 2]);
            end
            chk_irq(exp_irq);
        end
        events = '0;
        $display("test random routing done");
        for (int k = 0; k < 20 && q.size() != 0; k++) @(posedge mclk);
        if (q.size() != 0) begin
            n_fail++;
            $display("ERROR t=%0t reads left unanswered", $time);
        end
        close_out();
    end
endmodule : testbench
`default_nettype wire
